// >>> rtl/dlic_pkg.sv
// Constants shared by the dual-level interrupt controller
package dlic_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;

    // Register byte addresses
    localparam logic [31:0] OFF_NSTAT = 32'hFFFF0000;
    localparam logic [31:0] OFF_NRAW = 32'hFFFF0004;
    localparam logic [31:0] OFF_NEN = 32'hFFFF0008;
    localparam logic [31:0] OFF_NCLR = 32'hFFFF000C;
    localparam logic [31:0] OFF_SOFT_CFG = 32'hFFFF0010;
    localparam logic [31:0] OFF_FSTAT = 32'hFFFF0100;
    localparam logic [31:0] OFF_FRAW = 32'hFFFF0104;
    localparam logic [31:0] OFF_FEN = 32'hFFFF0108;
    localparam logic [31:0] OFF_FCLR = 32'hFFFF010C;
    localparam logic [31:0] OFF_EVSTAT = 32'hFFFF0200;
    localparam logic [31:0] OFF_EVMASK = 32'hFFFF0204;

    // Source bit positions
    localparam int BIT_OR = 0;
    localparam int BIT_SOFT = 1;
    localparam int BIT_SRC_LO = 2;
    localparam int BIT_SRC_HI = 22;
    localparam int BIT_PWM = 23;
    localparam int N_PERIPH = BIT_SRC_HI - BIT_SRC_LO + 1;

    // Software interrupt configuration fields
    localparam int SOFT_NORM_BIT = 1;
    localparam int SOFT_FAST_BIT = 2;
    localparam logic [31:0] SOFT_WMASK = 32'h00000006;

    // Block event register fields
    localparam int EV_W = 2;
    localparam int EV_NORM_RISE = 0;
    localparam int EV_FAST_RISE = 1;

    // Values after reset
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [EV_W-1:0] RST_EV = 2'h0;

endpackage : dlic_pkg

// >>> rtl/dlic_enable_pair.sv
// Paired normal and fast enable masks with mutual exclusion
`timescale 1ns/1ps
`default_nettype none
module dlic_enable_pair
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [dlic_pkg::DATA_W-1:0] set_norm,
    input wire logic [dlic_pkg::DATA_W-1:0] clr_norm,
    input wire logic [dlic_pkg::DATA_W-1:0] set_fast,
    input wire logic [dlic_pkg::DATA_W-1:0] clr_fast,
    output logic [dlic_pkg::DATA_W-1:0] norm_en,
    output logic [dlic_pkg::DATA_W-1:0] fast_en
);
    import dlic_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // One bit pair per source; a set on one path drops the other path
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_bit
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    norm_en[gi] <= 1'b0;
                    fast_en[gi] <= 1'b0;
                end
                else if (set_norm[gi])
                begin
                    norm_en[gi] <= 1'b1;
                    fast_en[gi] <= 1'b0;
                end
                else if (set_fast[gi])
                begin
                    fast_en[gi] <= 1'b1;
                    norm_en[gi] <= 1'b0;
                end
                else
                begin
                    // Clears may leave a source off on both paths
                    if (clr_norm[gi])
                        norm_en[gi] <= 1'b0;
                    if (clr_fast[gi])
                        fast_en[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    chk_never_both: assert property (
        @(posedge pclk) disable iff (!presetn)
        (norm_en & fast_en) == RST_WORD)
        else $error("source enabled on both paths");

    chk_clear_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        (clr_fast != RST_WORD && set_norm == RST_WORD
            && set_fast == RST_WORD)
        |=> (norm_en == $past(norm_en)))
        else $error("fast clear disturbed normal mask");

endmodule : dlic_enable_pair
`default_nettype wire

// >>> rtl/dlic_top.sv
// Dual-level interrupt controller with APB register access
// Function
// - Normal clear write drops enable bits written 1, others kept
// - Enable write only sets bits; clear register only clears bits
// - Fast path has its own status, raw, enable, clear registers
// - Fast output is OR of fast status bits 31 to 1
// - Fast OR appears as bit 0 in both register sets
// - Fast enable set clears same normal enable bit
// - Normal enable set clears same fast enable bit
// - A source may be disabled on both paths
// - Software interrupts bypass enable masks, cannot be masked
// - Config bit 2 drives fast status and raw bit 1
// - Config bit 1 drives normal status and raw bit 1
// - Normal status is raw AND enable; all bits ORed to output
// - Raw bit follows its peripheral request; register read-only
// - Enable 1 passes source, 0 masks; enables reset to zero
// - Bits 2 to 23 map fixed sources; bit 23 differs per path
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dlic_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dlic_pkg::ADDR_W-1:0] paddr,
    input wire logic [dlic_pkg::DATA_W-1:0] pwdata,
    output logic [dlic_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dlic_pkg::N_PERIPH-1:0] periph_req,
    input wire logic pwm_trip,
    input wire logic pwm_sync,
    output logic irq_req,
    output logic fiq_req,
    output logic int_out
);
    import dlic_pkg::*;

    logic [DATA_W-1:0] norm_status;
    logic [DATA_W-1:0] norm_raw;
    logic [DATA_W-1:0] fast_status;
    logic [DATA_W-1:0] fast_raw;
    logic [DATA_W-1:0] soft_cfg;
    logic [DATA_W-1:0] norm_en;
    logic [DATA_W-1:0] fast_en;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic [DATA_W-1:0] next_norm_raw;
    logic [DATA_W-1:0] next_fast_raw;
    logic [DATA_W-1:0] next_norm_status;
    logic [DATA_W-1:0] next_fast_status;
    logic [DATA_W-1:0] next_prdata;
    logic [DATA_W-1:0] wr_nen;
    logic [DATA_W-1:0] wr_nclr;
    logic [DATA_W-1:0] wr_fen;
    logic [DATA_W-1:0] wr_fclr;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic next_irq;
    logic next_fiq;
    logic next_err;
    logic setup;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic hit;

    ////////////////////////////////////////////////////////////////////
    // APB phases; the slave always answers in the first access cycle
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_acc = access && pwrite && !pslverr;
    assign rd_acc = access && !pwrite && !pslverr;

    always_comb
    begin
        case (paddr)
            OFF_NSTAT, OFF_NRAW, OFF_NEN, OFF_NCLR, OFF_SOFT_CFG,
            OFF_FSTAT, OFF_FRAW, OFF_FEN, OFF_FCLR,
            OFF_EVSTAT, OFF_EVMASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read data is gathered in the setup cycle so prdata is a flop
    always_comb
    begin
        next_prdata = RST_WORD;
        case (paddr)
            OFF_NSTAT: next_prdata = norm_status;
            OFF_NRAW: next_prdata = norm_raw;
            OFF_NEN: next_prdata = norm_en;
            OFF_FSTAT: next_prdata = fast_status;
            OFF_FRAW: next_prdata = fast_raw;
            OFF_FEN: next_prdata = fast_en;
            OFF_EVSTAT: next_prdata = {30'h00000000, ev_status};
            OFF_EVMASK: next_prdata = {30'h00000000, ev_mask};
            // Clear and config registers are write-only and read zero
            default: next_prdata = RST_WORD;
        endcase
    end

    assign next_err = !hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= RST_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            if (setup)
            begin
                prdata <= pwrite ? RST_WORD : next_prdata;
                pslverr <= next_err;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write strobes into the enable masks, gated by the access edge
    always_comb
    begin
        wr_nen = RST_WORD;
        wr_nclr = RST_WORD;
        wr_fen = RST_WORD;
        wr_fclr = RST_WORD;
        if (wr_acc)
        begin
            case (paddr)
                OFF_NEN: wr_nen = pwdata;
                OFF_NCLR: wr_nclr = pwdata;
                OFF_FEN: wr_fen = pwdata;
                OFF_FCLR: wr_fclr = pwdata;
                default: wr_nen = RST_WORD;
            endcase
        end
    end

    dlic_enable_pair u_enables
    (
        .pclk(pclk),
        .presetn(presetn),
        .set_norm(wr_nen),
        .clr_norm(wr_nclr),
        .set_fast(wr_fen),
        .clr_fast(wr_fclr),
        .norm_en(norm_en),
        .fast_en(fast_en)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            soft_cfg <= RST_WORD;
        else if (wr_acc && paddr == OFF_SOFT_CFG)
            soft_cfg <= pwdata & SOFT_WMASK;
    end

    ////////////////////////////////////////////////////////////////////
    // Source assembly; requests are sampled once per clock
    always_comb
    begin
        next_norm_raw = RST_WORD;
        next_fast_raw = RST_WORD;
        next_norm_raw[BIT_OR] = |fast_status[DATA_W-1:1];
        next_fast_raw[BIT_OR] = |fast_status[DATA_W-1:1];
        next_norm_raw[BIT_SOFT] = soft_cfg[SOFT_NORM_BIT];
        next_fast_raw[BIT_SOFT] = soft_cfg[SOFT_FAST_BIT];
        next_norm_raw[BIT_SRC_HI:BIT_SRC_LO] = periph_req;
        next_fast_raw[BIT_SRC_HI:BIT_SRC_LO] = periph_req;
        next_norm_raw[BIT_PWM] = pwm_trip;
        next_fast_raw[BIT_PWM] = pwm_sync;
    end

    // Software bit goes straight to status with no enable in the way
    always_comb
    begin
        next_norm_status = next_norm_raw & norm_en;
        next_fast_status = next_fast_raw & fast_en;
        next_norm_status[BIT_SOFT] = next_norm_raw[BIT_SOFT];
        next_fast_status[BIT_SOFT] = next_fast_raw[BIT_SOFT];
        next_irq = |next_norm_status;
        next_fiq = |next_fast_status[DATA_W-1:1];
    end

    // A request shorter than one clock may be missed entirely
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            norm_raw <= RST_WORD;
            fast_raw <= RST_WORD;
            norm_status <= RST_WORD;
            fast_status <= RST_WORD;
        end
        else
        begin
            norm_raw <= next_norm_raw;
            fast_raw <= next_fast_raw;
            norm_status <= next_norm_status;
            fast_status <= next_fast_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_req <= 1'b0;
            fiq_req <= 1'b0;
        end
        else
        begin
            irq_req <= next_irq;
            fiq_req <= next_fiq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Block events: rising core requests, cleared by reading
    assign ev_set[EV_NORM_RISE] = next_irq && !irq_req;
    assign ev_set[EV_FAST_RISE] = next_fiq && !fiq_req;
    // Only bits that were returned are cleared, so none is lost
    assign ev_clr = (rd_acc && paddr == OFF_EVSTAT) ?
        prdata[EV_W-1:0] : RST_EV;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_status <= RST_EV;
        else
            ev_status <= (ev_status & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_mask <= RST_EV;
        else if (wr_acc && paddr == OFF_EVMASK)
            ev_mask <= pwdata[EV_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_out <= 1'b0;
        else
            int_out <= |(((ev_status & ~ev_clr) | ev_set) & ev_mask);
    end

    ////////////////////////////////////////////////////////////////////
    chk_nclr_effect: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == OFF_NCLR)
        |=> norm_en == ($past(norm_en) & ~$past(pwdata)))
        else $error("normal clear wrong result");

    chk_nen_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == OFF_NEN)
        |=> norm_en == ($past(norm_en) | $past(pwdata))
            && fast_en == ($past(fast_en) & ~$past(pwdata)))
        else $error("normal enable write wrong result");

    chk_fen_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == OFF_FEN)
        |=> fast_en == ($past(fast_en) | $past(pwdata))
            && norm_en == ($past(norm_en) & ~$past(pwdata)))
        else $error("fast enable write wrong result");

    chk_fiq_or: assert property (
        @(posedge pclk) disable iff (!presetn)
        fiq_req == |fast_status[DATA_W-1:1])
        else $error("fast output not OR of status");

    chk_or_bit0: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 norm_raw[BIT_OR] == $past(|fast_status[DATA_W-1:1])
            && fast_raw[BIT_OR] == norm_raw[BIT_OR])
        else $error("bit 0 does not carry fast OR");

    chk_soft_fast: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == OFF_SOFT_CFG)
        |=> ##1 fast_status[BIT_SOFT] == $past(pwdata[SOFT_FAST_BIT], 2)
            && fast_raw[BIT_SOFT] == fast_status[BIT_SOFT])
        else $error("fast software bit not followed");

    chk_soft_norm: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == OFF_SOFT_CFG)
        |=> ##1 norm_status[BIT_SOFT] == $past(pwdata[SOFT_NORM_BIT], 2)
            && norm_raw[BIT_SOFT] == norm_status[BIT_SOFT])
        else $error("normal software bit not followed");

    chk_irq_or: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_req == |norm_status)
        else $error("normal output not OR of status");

    chk_fast_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 fast_status[DATA_W-1:2]
            == (fast_raw[DATA_W-1:2] & $past(fast_en[DATA_W-1:2])))
        else $error("fast status not raw and enable");

    chk_raw_follow: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 norm_raw[BIT_SRC_HI:BIT_SRC_LO] == $past(periph_req))
        else $error("raw bits do not follow requests");

endmodule : dlic_top
`default_nettype wire

// >>> bench/dlic_core_model.sv
// Core-side model that counts the exceptions it would take
`timescale 1ns/1ps
`default_nettype none
module dlic_core_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_req,
    input wire logic fiq_req,
    output int n_irq,
    output int n_fiq
);
    logic irq_d;
    logic fiq_d;
    // A level request counts once per rise; the core only sees edges of entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_d <= 1'b0;
            fiq_d <= 1'b0;
            n_irq <= 0;
            n_fiq <= 0;
        end
        else
        begin
            irq_d <= irq_req;
            fiq_d <= fiq_req;
            if (irq_req && !irq_d)
                n_irq <= n_irq + 1;
            if (fiq_req && !fiq_d)
                n_fiq <= n_fiq + 1;
        end
    end
endmodule : dlic_core_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the dual-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dlic_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic pwm_trip, pwm_sync, irq_req, fiq_req, int_out, rerr;
    logic [N_PERIPH-1:0] periph_req;
    int n_irq, n_fiq, mismatches, n_tests;
    dlic_top DUT
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
        .pwm_trip(pwm_trip), .pwm_sync(pwm_sync), .irq_req(irq_req),
        .fiq_req(fiq_req), .int_out(int_out)
    );
    dlic_core_model core
    (
        .pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .fiq_req(fiq_req), .n_irq(n_irq), .n_fiq(n_fiq)
    );
////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Starts one edge late so a release never meets the next request
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rdat, exp);
    endtask : rd
    task automatic outs(input logic i, input logic f);
        repeat (3) @(posedge pclk);
        chk({30'h0, irq_req, fiq_req}, {30'h0, i, f});
    endtask : outs
////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(OFF_NEN, RST_WORD);
        rd(OFF_FEN, RST_WORD);
        rd(OFF_NSTAT, RST_WORD);
        rd(OFF_FSTAT, RST_WORD);
        rd(OFF_NRAW, RST_WORD);
        outs(1'b0, 1'b0);
    endtask : t_reset
    task automatic t_masks;
        wr(OFF_NEN, 32'h0000000C);
        wr(OFF_NEN, 32'h00000010);
        rd(OFF_NEN, 32'h0000001C);
        wr(OFF_NCLR, 32'h00000004);
        rd(OFF_NEN, 32'h00000018);
        rd(OFF_NCLR, 32'h00000000);
        wr(OFF_FEN, 32'h00000300);
        wr(OFF_FCLR, 32'h00000100);
        rd(OFF_FEN, 32'h00000200);
        wr(OFF_FEN, 32'h00000008);
        rd(OFF_FEN, 32'h00000208);
        rd(OFF_NEN, 32'h00000010);
        wr(OFF_NEN, 32'h00000008);
        rd(OFF_FEN, 32'h00000200);
        rd(OFF_NEN, 32'h00000018);
        wr(OFF_NCLR, 32'h00000008);
        rd(OFF_NEN, 32'h00000010);
        rd(OFF_FEN, 32'h00000200);
    endtask : t_masks
    // Source bit 4 moves from the normal to the fast path
    task automatic t_periph;
        periph_req[2] <= 1'b1;
        outs(1'b1, 1'b0);
        rd(OFF_NRAW, 32'h00000010);
        rd(OFF_NSTAT, 32'h00000010);
        wr(OFF_FEN, 32'h00000010);
        outs(1'b0, 1'b1);
        rd(OFF_FSTAT, 32'h00000010);
        rd(OFF_FRAW, 32'h00000011);
        rd(OFF_NRAW, 32'h00000011);
        rd(OFF_NSTAT, 32'h00000000);
        // Fast bit 0 enabled must not hold the fast output up by itself
        wr(OFF_FEN, 32'h00000001);
        wr(OFF_FCLR, 32'h00000010);
        outs(1'b0, 1'b0);
        rd(OFF_FSTAT, 32'h00000000);
        rd(OFF_FRAW, 32'h00000010);
        wr(OFF_FCLR, 32'h00000001);
        periph_req[2] <= 1'b0;
        rd(OFF_FRAW, 32'h00000000);
    endtask : t_periph
    task automatic t_swi;
        wr(OFF_SOFT_CFG, 32'h00000002);
        outs(1'b1, 1'b0);
        rd(OFF_NRAW, 32'h00000002);
        rd(OFF_NSTAT, 32'h00000002);
        wr(OFF_SOFT_CFG, 32'h00000004);
        outs(1'b0, 1'b1);
        rd(OFF_FSTAT, 32'h00000002);
        rd(OFF_FRAW, 32'h00000003);
        rd(OFF_NSTAT, 32'h00000000);
        rd(OFF_SOFT_CFG, 32'h00000000);
        wr(OFF_SOFT_CFG, 32'h00000000);
        rd(OFF_FSTAT, 32'h00000000);
    endtask : t_swi
    task automatic t_pwm;
        periph_req <= 21'h100000;
        pwm_trip <= 1'b1;
        outs(1'b0, 1'b0);
        rd(OFF_NRAW, 32'h00C00000);
        rd(OFF_FRAW, 32'h00400000);
        pwm_trip <= 1'b0;
        pwm_sync <= 1'b1;
        rd(OFF_NRAW, 32'h00400000);
        rd(OFF_FRAW, 32'h00C00000);
        periph_req <= '0;
        pwm_sync <= 1'b0;
    endtask : t_pwm
    task automatic t_regs;
        apb(1'b0, 32'hFFFF0300, 32'h00000000);
        chk({rdat[30:0], rerr}, 32'h00000001);
        wr(OFF_NRAW, 32'hFFFFFFFF);
        rd(OFF_NRAW, 32'h00000000);
        wr(OFF_EVMASK, 32'h00000000);
        apb(1'b0, OFF_EVSTAT, 32'h00000000);
        wr(OFF_SOFT_CFG, 32'h00000002);
        outs(1'b1, 1'b0);
        chk({31'h0, int_out}, 32'h00000000);
        wr(OFF_EVMASK, 32'h00000001);
        repeat (3) @(posedge pclk);
        chk({31'h0, int_out}, 32'h00000001);
        rd(OFF_EVSTAT, 32'h00000001);
        repeat (3) @(posedge pclk);
        chk({31'h0, int_out}, 32'h00000000);
        wr(OFF_SOFT_CFG, 32'h00000000);
        chk(32'(n_irq), 32'h00000003);
        chk(32'(n_fiq), 32'h00000002);
    endtask : t_regs
////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Roughly 60 transfers of three cycles fit well inside this span
    initial
    begin
        #800000;
        mismatches++;
        final_report;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        periph_req = '0;
        pwm_trip = 1'b0;
        pwm_sync = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_masks;
        t_periph;
        t_swi;
        t_pwm;
        t_regs;
        final_report;
    end
endmodule : tb
`default_nettype wire
